//--- atps_pkg.sv
// Package of constants and types for the arbitrary transmit pulse segment block.
package atps_pkg;
    localparam int unsigned ATPS_ADDR_W   = 8;
    localparam int unsigned ATPS_SEGS     = 8;
    localparam int unsigned ATPS_AMP_W    = 7;
    localparam int unsigned ATPS_MAG_W    = 6;
    localparam int unsigned ATPS_SIGN_BIT = 6;
    // Register indices as printed; byte address is four times the index.
    localparam logic [4:0] ATPS_IDX_SEG1 = 5'h08;
    localparam logic [4:0] ATPS_IDX_SEG2 = 5'h09;
    localparam logic [4:0] ATPS_IDX_SEG3 = 5'h0a;
    localparam logic [4:0] ATPS_IDX_SEG4 = 5'h0b;
    localparam logic [4:0] ATPS_IDX_SEG5 = 5'h0c;
    localparam logic [4:0] ATPS_IDX_SEG6 = 5'h0d;
    localparam logic [4:0] ATPS_IDX_SEG7 = 5'h0e;
    localparam logic [4:0] ATPS_IDX_SEG8 = 5'h0f;
    localparam logic [4:0] ATPS_IDX_CTRL = 5'h10;
    localparam logic [4:0] ATPS_IDX_STAT = 5'h11;
    localparam logic [7:0] ATPS_SEG_RESET  = 8'h00;
    localparam logic [0:0] ATPS_CTRL_RESET = 1'h0;
    localparam int unsigned ATPS_CTRL_ARB_BIT = 0;
    // Master clock period in ns and ticks of pclk per slice of it.
    localparam int unsigned ATPS_MCLK_NS      = 80;
    localparam int unsigned ATPS_CLK_NS       = 10;
    localparam int unsigned ATPS_SLICE_CYCLES = ATPS_MCLK_NS / ATPS_CLK_NS / ATPS_SEGS;
    typedef logic [ATPS_AMP_W-1:0] atps_amp_t;
endpackage

//--- atps_seq_if.sv
// Interface carrying the segment sequencer signals between the two modules.
`timescale 1ns/1ns
interface atps_seq_if;
    logic       arb_mode;   // Arbitrary mode selected.
    logic [2:0] seg_index;  // Current slice index.
    logic       slice_tick; // Last cycle of a slice.
    modport sequencer (input arb_mode, output seg_index, output slice_tick);
    modport user      (output arb_mode, input seg_index, input slice_tick);
endinterface

//--- atps_seq.sv
// Slice sequencer that walks eight equal slices of each master clock period.
`timescale 1ns/1ns
module atps_seq
    import atps_pkg::*;
#(
    parameter int unsigned SLICE_CYCLES = ATPS_SLICE_CYCLES
) (
    input  wire logic  pclk,    // Clock.
    input  wire logic  presetn, // Asynchronous reset, active low.
    atps_seq_if.sequencer sq    // Sequencer signals.
);
    typedef struct packed {
        logic [15:0] cnt;
        logic [2:0]  seg;
    } atps_seq_s;
    atps_seq_s st;
    atps_seq_s next_st;
    logic      last;

    // Count cycles inside a slice and step to the next slice, wrapping after eight.
    always_comb begin
        next_st = st;
        last    = (st.cnt == 16'(SLICE_CYCLES - 1));
        if (!sq.arb_mode) begin
            next_st.cnt = 16'h0000;
            next_st.seg = 3'h0;
        end else if (last) begin
            next_st.cnt = 16'h0000;
            next_st.seg = st.seg + 3'h1;
        end else begin
            next_st.cnt = st.cnt + 16'h0001;
        end
    end

    // Register the sequencer state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sq.seg_index  = st.seg;
    assign sq.slice_tick = sq.arb_mode & last;
endmodule

//--- atps_top.sv
// Arbitrary transmit pulse segment registers with APB access and slice output.
`timescale 1ns/1ns
// Summary of operation
// - In arbitrary mode each pulse is split into eight equal slices spanning one master clock period.
// - Programmed amplitudes drive the output only when arbitrary mode is selected, else sign, magnitude and slice number are held at zero.
// - The second slice amplitude comes from bits 6 to 0 of register index 01001.
// - The third slice amplitude comes from bits 6 to 0 of register index 01010.
// - The fourth slice amplitude comes from bits 6 to 0 of register index 01011.
// - Each amplitude is signed magnitude with bit 6 as sign and bits 5 to 0 as magnitude.
// - Each amplitude register is read/write, resets to zero, and bit 7 is reserved read/write.
// - The first slice amplitude comes from bits 6 to 0 of register index 01000.
// - The fifth slice amplitude comes from bits 6 to 0 of register index 01100.
module atps_top
    import atps_pkg::*;
#(
    parameter int unsigned SLICE_CYCLES = ATPS_SLICE_CYCLES
) (
    input  wire logic                     pclk,         // Clock, 100 MHz.
    input  wire logic                     presetn,      // Asynchronous reset, active low.
    input  wire logic                     psel,         // APB select.
    input  wire logic                     penable,      // APB enable.
    input  wire logic                     pwrite,       // APB write.
    input  wire logic [ATPS_ADDR_W-1:0]   paddr,        // APB byte address.
    input  wire logic [31:0]              pwdata,       // APB write data.
    input  wire logic [3:0]               pstrb,        // APB byte strobes.
    output logic      [31:0]              prdata,       // APB read data.
    output logic                          pready,       // APB ready.
    output logic                          pslverr,      // APB error on unmapped address.
    output logic                          arb_active,   // Arbitrary mode in use.
    output logic                          seg_sign,     // Sign of current amplitude.
    output logic      [ATPS_MAG_W-1:0]    seg_magnitude,// Magnitude of current amplitude.
    output logic      [2:0]               seg_number    // Index of the current slice.
);
    import atps_pkg::*;

    typedef struct packed {
        logic [ATPS_SEGS-1:0][7:0] seg;
        logic                      arb;
        logic [31:0]               rdata;
        logic                      ready;
        logic                      err;
        logic                      act;
        logic                      sign;
        logic [ATPS_MAG_W-1:0]     mag;
        logic [2:0]                num;
    } atps_top_s;

    atps_top_s   st;
    atps_top_s   next_st;
    atps_seq_if  sq();
    logic [4:0]  idx;
    logic        hit_seg;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        aligned;
    logic        access;
    atps_amp_t   amp;

    assign sq.arb_mode = st.arb;

    atps_seq #(
        .SLICE_CYCLES (SLICE_CYCLES)
    ) u_seq (
        .pclk    (pclk),
        .presetn (presetn),
        .sq      (sq.sequencer)
    );

    // Decode the word index and classify the address.
    always_comb begin
        idx      = paddr[6:2];
        aligned  = (paddr[1:0] == 2'h0) && (paddr[7] == 1'b0);
        hit_seg  = aligned && (idx >= ATPS_IDX_SEG1) && (idx <= ATPS_IDX_SEG8);
        hit_ctrl = aligned && (idx == ATPS_IDX_CTRL);
        hit_stat = aligned && (idx == ATPS_IDX_STAT);
        access   = psel && penable && !st.ready;
        amp      = st.seg[sq.seg_index][ATPS_AMP_W-1:0];
    end

    // Bus slave, register file and slice output in one next-state process.
    always_comb begin
        next_st       = st;
        next_st.ready = 1'b0;
        next_st.err   = 1'b0;
        if (access) begin
            next_st.ready = 1'b1;
            next_st.rdata = 32'h0000_0000;
            if (!(hit_seg || hit_ctrl || hit_stat)) begin
                next_st.err = 1'b1;
            end else if (pwrite) begin
                if (hit_seg && pstrb[0]) begin
                    next_st.seg[3'(idx - ATPS_IDX_SEG1)] = pwdata[7:0];
                end
                if (hit_ctrl && pstrb[0]) begin
                    next_st.arb = pwdata[ATPS_CTRL_ARB_BIT];
                end
            end else if (hit_seg) begin
                next_st.rdata[7:0] = st.seg[3'(idx - ATPS_IDX_SEG1)];
            end else if (hit_ctrl) begin
                next_st.rdata[ATPS_CTRL_ARB_BIT] = st.arb;
            end else begin
                next_st.rdata[3:0] = {sq.seg_index, st.arb};
            end
        end
        // Present the current slice amplitude; zero output when not arbitrary.
        next_st.act = st.arb;
        if (st.arb) begin
            next_st.sign = amp[ATPS_SIGN_BIT];
            next_st.mag  = amp[ATPS_MAG_W-1:0];
            next_st.num  = sq.seg_index;
        end else begin
            next_st.sign = 1'b0;
            next_st.mag  = '0;
            next_st.num  = 3'h0;
        end
    end

    // Register all state; every register clears to zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st     <= '0;
            st.arb <= ATPS_CTRL_RESET;
            for (int i = 0; i < ATPS_SEGS; i++) begin
                st.seg[i] <= ATPS_SEG_RESET;
            end
        end else begin
            st <= next_st;
        end
    end

    assign prdata        = st.rdata;
    assign pready        = st.ready;
    assign pslverr       = st.err;
    assign arb_active    = st.act;
    assign seg_sign      = st.sign;
    assign seg_magnitude = st.mag;
    assign seg_number    = st.num;
endmodule

//--- atps_assertions.sv
// Checker for the APB reply and slice output of the pulse segment block.
`timescale 1ns/1ns
module atps_assertions
#(parameter int unsigned SLICE_CYCLES = 1) (
    input wire logic        pclk,          // Clock.
    input wire logic        presetn,       // Reset, active low.
    input wire logic        psel,          // Select.
    input wire logic        penable,       // Enable.
    input wire logic [31:0] prdata,        // Read data.
    input wire logic        pready,        // Ready.
    input wire logic        pslverr,       // Error.
    input wire logic        arb_active,    // Mode in use.
    input wire logic        seg_sign,      // Sign.
    input wire logic [5:0]  seg_magnitude, // Magnitude.
    input wire logic [2:0]  seg_number     // Slice.
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Reply timing, refusal, idle output and slice order, with covers of the main cases.
    chk_ready_follows: assert property (psel && penable && !pready |=> pready)
        else $error("no ready after access");
    chk_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("ready without access");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
    chk_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("bad error reply");
    chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_idle_zero: assert property (!arb_active && !$past(arb_active)
        |-> {seg_sign, seg_magnitude, seg_number} == 10'h0) else $error("output while idle");
    chk_slice_step: assert property (arb_active && $past(arb_active) && $changed(seg_number)
        |-> seg_number == $past(seg_number) + 3'h1 || seg_number == 3'h0) else $error("slice skip");
    chk_slice_hold: assert property (SLICE_CYCLES > 1 && arb_active && $changed(seg_number)
        |=> $stable(seg_number)) else $error("slice too short");
    cov_refused: cover property (pslverr);
    cov_wrap: cover property (arb_active && $past(seg_number) == 3'h7 && seg_number == 3'h0);
    cov_mode_on: cover property ($rose(arb_active));
endmodule
bind atps_top atps_assertions #(.SLICE_CYCLES(SLICE_CYCLES)) i_atps_assertions (.*);

//--- atps_top_tb_top.sv
// Self-checking bench for the pulse segment block.
`timescale 1ns/1ns
module atps_top_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, arb_active, seg_sign, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0]  seg_magnitude;
    logic [2:0]  seg_number;
    int          fails = 0, check_count = 0;
    logic [7:0]  vals [8] = '{8'h85, 8'hc1, 8'h3f, 8'hff, 8'h40, 8'h2a, 8'h01, 8'h7e};
    atps_top #(.SLICE_CYCLES(2)) i_atps_top (.pstrb(4'hf), .*);
    // Clock at 100 MHz.
    initial forever #5 pclk = ~pclk;
    // Counts a comparison and reports a mismatch.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        fails += (seen !== exp);
        if (seen !== exp)
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    endtask
    // One APB transfer; the reply lands in rd and er.
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic wrap_up();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Ends a hung run.
    initial begin
        #20000;
        fails++;
        wrap_up();
    end
    // Registers with junk upper bits, a refused address, the slices, then mode off.
    initial begin
        {pclk, psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            apb(8'h20 + 8'(4 * (i % 8)), 1'b0, 32'h0);
            chk("seg register", rd, i < 8 ? 32'h0 : {24'h0, vals[i % 8]});
            apb(8'h20 + 8'(4 * (i % 8)), i < 8, {24'hffffff, vals[i % 8]});
        end
        apb(8'h80, 1'b1, 32'h0);
        chk("refused", 32'(er), 32'h1);
        $display("test registers done");
        apb(8'h40, 1'b1, 32'h1);
        for (int k = 0; k < 10; k++) begin
            for (int n = 0; n < 64 && (seg_number !== 3'(k) || arb_active !== 1'b1); n++)
                @(negedge pclk);
            chk("amplitude", 32'({seg_sign, seg_magnitude}), 32'(vals[k % 8][6:0]));
        end
        $display("test slices done");
        apb(8'h40, 1'b1, 32'h0);
        repeat (3) @(negedge pclk);
        chk("idle", 32'({arb_active, seg_sign, seg_magnitude, seg_number}), 32'h0);
        $display("test mode off done");
        wrap_up();
    end
endmodule
